// ### smsg_initiator.sv
// Initiator model: sends message-out bytes and answers target reselection.
// Assumes the bench calls its tasks just after a rising edge of mclk.
`timescale 1ns/1ps
module smsg_initiator (
    // Clock
    input wire logic mclk,
    // Reselection from the target
    input wire logic resel_drive,
    // Message-out signals and reselection answer
    output logic msg_valid,
    output logic [7:0] msg_byte,
    output logic msg_par_err,
    output logic atn,
    output logic msg_end,
    output logic resel_resp
);
    int resp_delay = -1;
    int wait_cnt = 0;
    initial begin
        msg_valid = 1'b0;
        msg_byte = 8'h00;
        msg_par_err = 1'b0;
        atn = 1'b0;
        msg_end = 1'b0;
        resel_resp = 1'b0;
    end
    // Sends one byte, valid for one cycle.
    task automatic put(input logic [7:0] b, input logic pe, input logic a);
        msg_valid <= 1'b1;
        msg_byte <= b;
        msg_par_err <= pe;
        atn <= a;
        @(posedge mclk);
    endtask
    // Releases the data lines, which then show the inverse of the last byte.
    task automatic fin(input logic e);
        msg_valid <= 1'b0;
        msg_par_err <= 1'b0;
        msg_byte <= ~msg_byte;
        atn <= 1'b0;
        msg_end <= e;
        @(posedge mclk);
        msg_end <= 1'b0;
    endtask
    // Answers a reselection after resp_delay cycles; a negative delay never answers.
    always @(posedge mclk) begin
        if (resel_drive && resp_delay >= 0 && wait_cnt == resp_delay) begin
            resel_resp <= 1'b1;
        end else begin
            resel_resp <= 1'b0;
        end
        wait_cnt <= resel_drive ? wait_cnt + 1 : 0;
    end
endmodule

// ### smsg_pkg.sv
// Constants, types and helpers for the target message-out and status logic.
// Assumes a bus-phase sequencer outside that moves bytes and phases on the SCSI pins.
// Notes on behaviour
// - One status byte per command unless cleared.
// - Status code in bits 5..1, rest reserved.
// - Sense data set means Check Condition.
// - Report Busy when a command cannot be taken.
// - Intermediate for linked commands except the last.
// - Reservation Conflict on access to reserved unit.
// - Queue Full on tag with full queue.
// - Accept Identify prefix and No-Op fillers.
// - Two message types in one phase: illegal.
// - Over sixteen bytes with ATN: illegal, Bus Free.
// - Detected error messages abort with sense.
// - Abort clears status, goes Bus Free.
// - Reset message restores power-on state, Bus Free.
// - Trailing No-Op illegal except after reselection.
// - Reject of Disconnect or Save Pointer continues.
// - Rejected sync request forces asynchronous transfers.
// - Sync request only before first command.
// - Some errors end in Bus Free silently.
// - Message parity error aborts with parity sense.
// - Command or data parity error gives Check.
// - Illegal message aborts with illegal-message sense.
// - Reselection retried once, then hardware error.
// - Message byte codes decoded as listed.
package smsg_pkg;
    localparam logic [7:0] MSG_EXT = 8'h01;
    localparam logic [7:0] MSG_IDE = 8'h05;
    localparam logic [7:0] MSG_ABORT = 8'h06;
    localparam logic [7:0] MSG_REJECT = 8'h07;
    localparam logic [7:0] MSG_NOOP = 8'h08;
    localparam logic [7:0] MSG_MPE = 8'h09;
    localparam logic [7:0] MSG_BDR = 8'h0C;
    localparam logic [7:0] MSG_TAG_SIMPLE = 8'h20;
    localparam logic [7:0] MSG_TAG_ORDERED = 8'h22;
    localparam logic [7:0] EXT_SDTR = 8'h01;
    localparam logic [4:0] MSG_MAX = 5'h10;
    localparam logic [4:0] ST_GOOD = 5'h00;
    localparam logic [4:0] ST_CHECK = 5'h01;
    localparam logic [4:0] ST_BUSY = 5'h04;
    localparam logic [4:0] ST_INTER = 5'h08;
    localparam logic [4:0] ST_RESV = 5'h0C;
    localparam logic [4:0] ST_QFULL = 5'h14;
    localparam logic [3:0] KEY_ABORTED = 4'hB;
    localparam logic [3:0] KEY_HWERR = 4'h4;
    localparam logic [7:0] ASC_RESEL = 8'h45;
    localparam logic [7:0] ASC_PARITY = 8'h47;
    localparam logic [7:0] ASC_IDE = 8'h48;
    localparam logic [7:0] ASC_ILLEGAL = 8'h49;
    localparam int SEL_TIMEOUT_US = 250;
    localparam int CLK_MHZ = 200;
    typedef enum logic [3:0] {
        K_NONE = 4'b0000, K_IDENT = 4'b0001, K_NOOP = 4'b0010, K_IDE = 4'b0011,
        K_ABORT = 4'b0100, K_REJ = 4'b0101, K_BDR = 4'b0110, K_EXT = 4'b0111,
        K_SDTR = 4'b1000, K_TAG = 4'b1001, K_OTHER = 4'b1010
    } smsg_kind_t;
    typedef struct packed {
        logic [3:0] key;
        logic [7:0] code;
    } smsg_sense_t;
    typedef struct packed {
        logic start;
        logic done;
        logic linked;
        logic busy;
        logic conflict;
        logic parity_err;
    } smsg_cmd_ev_t;
    // Builds a status byte with the reserved bits at zero.
    function automatic logic [7:0] smsg_status(input logic [4:0] c);
        return {2'b00, c, 1'b0};
    endfunction
    // Sorts a leading message byte into its kind.
    function automatic smsg_kind_t smsg_classify(input logic [7:0] b);
        if (b[7]) begin
            return K_IDENT;
        end
        unique case (b)
            MSG_EXT: return K_EXT;
            MSG_IDE, MSG_MPE: return K_IDE;
            MSG_ABORT: return K_ABORT;
            MSG_REJECT: return K_REJ;
            MSG_NOOP: return K_NOOP;
            MSG_BDR: return K_BDR;
            default: return (b >= MSG_TAG_SIMPLE && b <= MSG_TAG_ORDERED) ? K_TAG : K_OTHER;
        endcase
    endfunction
endpackage

// ### smsg_target.sv
// Target message-out interpreter, status byte builder, sense and reselection retry.
// Assumes byte strobes and phase events from a sequencer synchronous to mclk.
`timescale 1ns/1ps
module smsg_target #(
    parameter int SEL_TIMEOUT_CYC = smsg_pkg::SEL_TIMEOUT_US * smsg_pkg::CLK_MHZ
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Message-out bytes
    input wire logic msg_valid,
    input wire logic [7:0] msg_byte,
    input wire logic msg_par_err,
    input wire logic atn,
    input wire logic msg_end,
    // Command context
    input wire smsg_pkg::smsg_cmd_ev_t cmd_ev,
    input wire logic lun_valid,
    input wire logic status_begun,
    input wire logic before_first_cmd,
    input wire logic msgin_disc_sdp,
    input wire logic msgin_sdtr,
    input wire logic queue_full,
    input wire logic parity_en,
    input wire logic self_start_sync_negotiation_option,
    input wire logic bus_reset,
    // Reselection
    input wire logic resel_start,
    input wire logic resel_resp,
    // Outcomes
    output logic status_valid,
    output logic [7:0] status_byte,
    output logic bus_free,
    output logic abort_cmd,
    output logic clear_status,
    output logic por_all,
    output logic continue_cmd,
    output logic continue_resel,
    output logic enqueue,
    output logic send_sdtr,
    output logic sync_mode,
    // Sense
    output logic sense_set,
    output smsg_pkg::smsg_sense_t sense,
    // Reselection drive
    output logic resel_drive,
    output logic resel_retry
);
    logic [4:0] cnt;
    logic [7:0] skip;
    logic [7:0] ext_len;
    logic [1:0] ext_st;
    logic par_seen;
    logic multi;
    logic last_noop;
    logic over;
    smsg_pkg::smsg_kind_t kind;
    smsg_pkg::smsg_kind_t kb;
    logic eval;
    logic e_par;
    logic e_ill;
    logic e_ide;
    logic err_any;
    logic err_status;
    logic ok;
    logic noop_resel;
    logic init_pend;
    logic cmd_active;
    logic sense_pend;
    logic resel_fail;
    logic resel_won;
    logic attempt;
    logic [31:0] timer;

    assign kb = smsg_pkg::smsg_classify(msg_byte);
    assign eval = msg_end | over;

    always_comb begin
        e_par = parity_en & par_seen;
        noop_resel = last_noop & (kind == smsg_pkg::K_NONE) & resel_won;
        e_ill = !e_par & (multi | over
            | (last_noop & !noop_resel)
            | (kind == smsg_pkg::K_REJ & !msgin_disc_sdp & !msgin_sdtr)
            | (kind == smsg_pkg::K_SDTR & !before_first_cmd)
            | (kind == smsg_pkg::K_EXT) | (kind == smsg_pkg::K_OTHER));
        e_ide = !e_par & !e_ill & (kind == smsg_pkg::K_IDE);
        err_any = e_par | e_ill | e_ide;
        err_status = err_any & lun_valid & !status_begun & !over;
        ok = !e_par & !e_ill;
    end

    // Message-out byte tracking.
    always_ff @(posedge mclk) begin
        if (rst || eval) begin
            cnt <= '0;
            skip <= '0;
            ext_len <= '0;
            ext_st <= 2'b00;
            par_seen <= 1'b0;
            multi <= 1'b0;
            last_noop <= 1'b0;
            over <= 1'b0;
            kind <= smsg_pkg::K_NONE;
        end else if (msg_valid && cnt != smsg_pkg::MSG_MAX) begin
            cnt <= cnt + 5'h01;
            par_seen <= par_seen | msg_par_err;
            over <= atn && (cnt == smsg_pkg::MSG_MAX - 5'h01);
            if (skip != '0) begin
                skip <= skip - 8'h01;
            end else if (ext_st == 2'b01) begin
                ext_len <= msg_byte;
                ext_st <= 2'b10;
            end else if (ext_st == 2'b10) begin
                kind <= (msg_byte == smsg_pkg::EXT_SDTR) ? smsg_pkg::K_SDTR : smsg_pkg::K_OTHER;
                skip <= (ext_len == '0) ? '0 : ext_len - 8'h01;
                ext_st <= 2'b00;
            end else if (kb == smsg_pkg::K_NOOP) begin
                last_noop <= 1'b1;
            end else if (kb != smsg_pkg::K_IDENT) begin
                last_noop <= 1'b0;
                multi <= multi | (kind != smsg_pkg::K_NONE);
                kind <= kb;
                if (kb == smsg_pkg::K_EXT) begin
                    ext_st <= 2'b01;
                end
                if (kb == smsg_pkg::K_TAG) begin
                    skip <= 8'h01;
                end
            end
        end
    end

    // Actions that follow a message-out phase, a reset or a failed reselection.
    always_ff @(posedge mclk) begin
        abort_cmd <= 1'b0;
        bus_free <= 1'b0;
        clear_status <= 1'b0;
        por_all <= 1'b0;
        continue_cmd <= 1'b0;
        continue_resel <= 1'b0;
        enqueue <= 1'b0;
        send_sdtr <= 1'b0;
        if (rst) begin
            init_pend <= 1'b1;
        end else begin
            init_pend <= 1'b0;
            if ((init_pend | por_all) & self_start_sync_negotiation_option) begin
                send_sdtr <= 1'b1;
            end
            if (resel_fail) begin
                abort_cmd <= 1'b1;
            end
            if (bus_reset) begin
                abort_cmd <= 1'b1;
                por_all <= 1'b1;
            end else if (eval) begin
                if (err_any) begin
                    abort_cmd <= 1'b1;
                    bus_free <= !err_status;
                end
                if (ok && kind == smsg_pkg::K_ABORT) begin
                    abort_cmd <= 1'b1;
                    clear_status <= 1'b1;
                    bus_free <= 1'b1;
                end
                if (ok && kind == smsg_pkg::K_BDR) begin
                    abort_cmd <= 1'b1;
                    por_all <= 1'b1;
                    bus_free <= 1'b1;
                end
                continue_cmd <= ok & (kind == smsg_pkg::K_REJ) & msgin_disc_sdp;
                continue_resel <= ok & noop_resel;
                send_sdtr <= ok & (kind == smsg_pkg::K_SDTR);
                enqueue <= ok & (kind == smsg_pkg::K_TAG) & !queue_full;
            end
        end
    end

    // Status byte and command life.
    always_ff @(posedge mclk) begin
        status_valid <= 1'b0;
        if (rst || bus_reset || por_all) begin
            status_byte <= '0;
            cmd_active <= 1'b0;
        end else begin
            if (cmd_ev.start) begin
                cmd_active <= 1'b1;
            end
            if (eval && err_any) begin
                cmd_active <= 1'b0;
                if (err_status) begin
                    status_valid <= 1'b1;
                    status_byte <= smsg_pkg::smsg_status(smsg_pkg::ST_CHECK);
                end
            end else if (eval && ok && (kind == smsg_pkg::K_ABORT || kind == smsg_pkg::K_BDR)) begin
                cmd_active <= 1'b0;
            end else if (eval && ok && kind == smsg_pkg::K_TAG && queue_full) begin
                status_valid <= 1'b1;
                status_byte <= smsg_pkg::smsg_status(smsg_pkg::ST_QFULL);
            end else if (cmd_ev.parity_err && parity_en && cmd_active) begin
                status_valid <= 1'b1;
                status_byte <= smsg_pkg::smsg_status(smsg_pkg::ST_CHECK);
                cmd_active <= 1'b0;
            end else if (cmd_ev.busy) begin
                status_valid <= 1'b1;
                status_byte <= smsg_pkg::smsg_status(smsg_pkg::ST_BUSY);
            end else if (cmd_ev.conflict) begin
                status_valid <= 1'b1;
                status_byte <= smsg_pkg::smsg_status(smsg_pkg::ST_RESV);
            end else if (cmd_ev.done && cmd_active) begin
                status_valid <= 1'b1;
                if (sense_pend) begin
                    status_byte <= smsg_pkg::smsg_status(smsg_pkg::ST_CHECK);
                end else if (cmd_ev.linked) begin
                    status_byte <= smsg_pkg::smsg_status(smsg_pkg::ST_INTER);
                end else begin
                    status_byte <= smsg_pkg::smsg_status(smsg_pkg::ST_GOOD);
                end
                cmd_active <= cmd_ev.linked & !sense_pend;
            end else if (resel_fail) begin
                cmd_active <= 1'b0;
            end
        end
    end

    // Sense data; a new setting wins over the clear by a Check status.
    always_ff @(posedge mclk) begin
        sense_set <= 1'b0;
        if (rst) begin
            sense_pend <= 1'b0;
            sense <= '0;
        end else begin
            if (por_all || (status_valid && status_byte == smsg_pkg::smsg_status(smsg_pkg::ST_CHECK))) begin
                sense_pend <= 1'b0;
            end
            if (eval && err_any && !bus_reset) begin
                sense_set <= 1'b1;
                sense_pend <= 1'b1;
                sense.key <= smsg_pkg::KEY_ABORTED;
                sense.code <= e_par ? smsg_pkg::ASC_PARITY :
                    (e_ill ? smsg_pkg::ASC_ILLEGAL : smsg_pkg::ASC_IDE);
            end else if (cmd_ev.parity_err && parity_en && cmd_active) begin
                sense_set <= 1'b1;
                sense_pend <= 1'b1;
                sense.key <= smsg_pkg::KEY_ABORTED;
                sense.code <= smsg_pkg::ASC_PARITY;
            end else if (resel_fail) begin
                sense_set <= 1'b1;
                sense_pend <= 1'b1;
                sense.key <= smsg_pkg::KEY_HWERR;
                sense.code <= smsg_pkg::ASC_RESEL;
            end
        end
    end

    // Synchronous transfer agreement.
    always_ff @(posedge mclk) begin
        if (rst || por_all) begin
            sync_mode <= 1'b0;
        end else if (eval && ok && kind == smsg_pkg::K_SDTR) begin
            sync_mode <= 1'b1;
        end else if (eval && ok && kind == smsg_pkg::K_REJ && msgin_sdtr && !msgin_disc_sdp) begin
            sync_mode <= 1'b0;
        end
    end

    // Reselection with one retry after a timeout.
    always_ff @(posedge mclk) begin
        resel_fail <= 1'b0;
        resel_retry <= 1'b0;
        if (rst || por_all) begin
            resel_drive <= 1'b0;
            resel_won <= 1'b0;
            attempt <= 1'b0;
            timer <= '0;
        end else begin
            if (eval) begin
                resel_won <= 1'b0;
            end
            if (resel_start && !resel_drive) begin
                resel_drive <= 1'b1;
                attempt <= 1'b0;
                timer <= '0;
            end else if (resel_drive) begin
                if (resel_resp) begin
                    resel_drive <= 1'b0;
                    resel_won <= 1'b1;
                end else if (timer == 32'(SEL_TIMEOUT_CYC - 1)) begin
                    timer <= '0;
                    if (attempt) begin
                        resel_drive <= 1'b0;
                        resel_fail <= 1'b1;
                    end else begin
                        attempt <= 1'b1;
                        resel_retry <= 1'b1;
                    end
                end else begin
                    timer <= timer + 32'h0000_0001;
                end
            end
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    status_reserved_a: assert property (status_valid |-> status_byte[7:6] == 2'b00 && !status_byte[0])
        else $error("status reserved bits set");
    illegal_check_a: assert property (eval && e_ill && err_status && !bus_reset |=>
        status_valid && status_byte == 8'h02 && sense.code == smsg_pkg::ASC_ILLEGAL)
        else $error("illegal message did not end in check");
    parity_sense_a: assert property (eval && e_par && !bus_reset |=> sense_set &&
        sense.key == smsg_pkg::KEY_ABORTED && sense.code == smsg_pkg::ASC_PARITY)
        else $error("parity sense missing");
    ide_free_a: assert property (eval && e_ide && !err_status && !bus_reset |=> bus_free && abort_cmd)
        else $error("detected error did not free bus");
    abort_quiet_a: assert property (eval && ok && kind == smsg_pkg::K_ABORT && !bus_reset |=>
        bus_free && clear_status && !status_valid)
        else $error("abort handled wrongly");
    bdr_por_a: assert property (eval && ok && kind == smsg_pkg::K_BDR && !bus_reset |=> por_all && bus_free)
        else $error("device reset handled wrongly");
    overrun_free_a: assert property (over && !bus_reset |=> bus_free && abort_cmd && !status_valid)
        else $error("overrun did not free bus");
    resel_fail_a: assert property (resel_fail |=> sense_set && sense.code == smsg_pkg::ASC_RESEL &&
        abort_cmd && !resel_drive)
        else $error("reselect failure handled wrongly");
    reject_async_a: assert property (eval && ok && kind == smsg_pkg::K_REJ && msgin_sdtr && !msgin_disc_sdp
        && !bus_reset |=> !sync_mode)
        else $error("sync kept after reject");
    check_pend_a: assert property (cmd_ev.done && cmd_active && sense_pend && !eval && !bus_reset && !por_all
        && !cmd_ev.busy && !cmd_ev.conflict && !cmd_ev.parity_err |=> status_byte == 8'h02)
        else $error("pending sense not reported");

    cover property (eval && e_ill && err_status);
    cover property (resel_retry ##[1:1000] resel_fail);
    cover property (status_valid && status_byte == 8'h10);
    cover property (continue_resel);
endmodule

// ### test_smsg_target.sv
// Self-checking bench for the target message-out and status logic.
// Assumes smsg_pkg, smsg_target and smsg_initiator are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module test_smsg_target;
    localparam int TMO = 12;
    localparam logic [10:0] SV = 11'h400, BF = 11'h200, AB = 11'h100, CS = 11'h080, POR = 11'h040;
    localparam logic [10:0] CC = 11'h020, CR = 11'h010, ENQ = 11'h008, SD = 11'h004, SS = 11'h002;
    localparam logic [10:0] RT = 11'h001;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic clr = 1'b1;
    logic [10:0] seen = 11'h000;
    int fail_count = 0;
    int check_count = 0;
    smsg_pkg::smsg_cmd_ev_t cmd_ev = '0;
    logic lun_valid = 1'b1, status_begun = 1'b0, before_first_cmd = 1'b1, msgin_disc_sdp = 1'b0;
    logic msgin_sdtr = 1'b0, queue_full = 1'b0, parity_en = 1'b1, self_start_sync_negotiation_option = 1'b1;
    logic bus_reset = 1'b0, resel_start = 1'b0;
    logic msg_valid, msg_par_err, atn, msg_end, resel_resp;
    logic [7:0] msg_byte, status_byte;
    logic status_valid, bus_free, abort_cmd, clear_status, por_all, continue_cmd, continue_resel, enqueue;
    logic send_sdtr, sync_mode, sense_set, resel_drive, resel_retry;
    smsg_pkg::smsg_sense_t sense;
    always #2.5 mclk = ~mclk;
    smsg_target #(.SEL_TIMEOUT_CYC(TMO)) uut (.mclk, .rst, .msg_valid, .msg_byte, .msg_par_err, .atn, .msg_end,
        .cmd_ev, .lun_valid, .status_begun, .before_first_cmd, .msgin_disc_sdp, .msgin_sdtr, .queue_full,
        .parity_en, .self_start_sync_negotiation_option, .bus_reset, .resel_start, .resel_resp, .status_valid,
        .status_byte, .bus_free, .abort_cmd, .clear_status, .por_all, .continue_cmd, .continue_resel, .enqueue,
        .send_sdtr, .sync_mode, .sense_set, .sense, .resel_drive, .resel_retry);
    smsg_initiator ini (.mclk, .resel_drive, .msg_valid, .msg_byte, .msg_par_err, .atn, .msg_end, .resel_resp);
    // Collects every outcome pulse since the last clear.
    always @(posedge mclk) begin
        seen <= clr ? 11'h000 : seen | {status_valid, bus_free, abort_cmd, clear_status, por_all, continue_cmd,
            continue_resel, enqueue, send_sdtr, sense_set, resel_retry};
    end
    task automatic test_done();
        $display("Comparisons: %0d, mismatches: %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic clear();
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
    endtask
    task automatic pulse_ev(input logic [5:0] v);
        cmd_ev <= v;
        @(posedge mclk);
        cmd_ev <= '0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic judge(input logic [10:0] m, input logic [7:0] st, input logic [11:0] sn);
        `CHK(seen, m)
        if (m[10]) `CHK(status_byte, st)
        if (m[1]) `CHK(sense, sn)
    endtask
    // Sends n bytes, first byte highest in v; byte index bad carries a parity error.
    task automatic mo(input logic [63:0] v, input int n, input int bad);
        clear();
        for (int i = n - 1; i >= 0; i--) begin
            ini.put(v[8*i +: 8], i == bad, i != 0);
        end
        ini.fin(1'b1);
        repeat (3) @(posedge mclk);
    endtask
    task automatic t_status();
        `CHK(seen & SD, SD)
        `CHK(sync_mode, 1'b0)
        clear();
        pulse_ev(6'h20);
        pulse_ev(6'h18);
        judge(SV, 8'h10, 12'h000);
        clear();
        pulse_ev(6'h10);
        judge(SV, 8'h00, 12'h000);
        clear();
        pulse_ev(6'h04);
        judge(SV, 8'h08, 12'h000);
        clear();
        pulse_ev(6'h02);
        judge(SV, 8'h18, 12'h000);
        clear();
        pulse_ev(6'h20);
        pulse_ev(6'h01);
        judge(SV | SS, 8'h02, 12'hB47);
        $display("t_status finished");
    endtask
    task automatic t_msgs();
        mo(64'h8008_0806, 4, -1);
        judge(AB | CS | BF, 8'h00, 12'h000);
        mo(64'h0C, 1, -1);
        `CHK(seen & ~SD, AB | POR | BF)
        repeat (3) @(posedge mclk);
        mo(64'h060C, 2, -1);
        judge(AB | SV | SS, 8'h02, 12'hB49);
        mo(64'h0608, 2, -1);
        judge(AB | SV | SS, 8'h02, 12'hB49);
        mo(64'h07, 1, -1);
        judge(AB | SV | SS, 8'h02, 12'hB49);
        msgin_disc_sdp <= 1'b1;
        mo(64'h07, 1, -1);
        judge(CC, 8'h00, 12'h000);
        msgin_disc_sdp <= 1'b0;
        $display("t_msgs finished");
    endtask
    task automatic t_errors();
        mo(64'h05, 1, -1);
        judge(AB | SV | SS, 8'h02, 12'hB48);
        lun_valid <= 1'b0;
        mo(64'h09, 1, -1);
        judge(AB | BF | SS, 8'h00, 12'hB48);
        pulse_ev(6'h20);
        clear();
        pulse_ev(6'h10);
        judge(SV, 8'h02, 12'h000);
        lun_valid <= 1'b1;
        mo(64'h8006, 2, 0);
        judge(AB | SV | SS, 8'h02, 12'hB47);
        status_begun <= 1'b1;
        mo(64'h06, 1, 0);
        judge(AB | BF | SS, 8'h00, 12'hB47);
        status_begun <= 1'b0;
        parity_en <= 1'b0;
        mo(64'h06, 1, 0);
        judge(AB | CS | BF, 8'h00, 12'h000);
        parity_en <= 1'b1;
        $display("t_errors finished");
    endtask
    task automatic t_sync();
        mo(64'h01_0301_1908, 5, -1);
        judge(SD, 8'h00, 12'h000);
        `CHK(sync_mode, 1'b1)
        msgin_sdtr <= 1'b1;
        mo(64'h07, 1, -1);
        `CHK(sync_mode, 1'b0)
        msgin_sdtr <= 1'b0;
        before_first_cmd <= 1'b0;
        mo(64'h01_0301_1908, 5, -1);
        judge(AB | SV | SS, 8'h02, 12'hB49);
        before_first_cmd <= 1'b1;
        mo(64'h0102_0300, 4, -1);
        judge(AB | SV | SS, 8'h02, 12'hB49);
        $display("t_sync finished");
    endtask
    task automatic t_bus_reset();
        mo(64'h01_0301_1908, 5, -1);
        `CHK(sync_mode, 1'b1)
        self_start_sync_negotiation_option <= 1'b0;
        pulse_ev(6'h20);
        clear();
        bus_reset <= 1'b1;
        @(posedge mclk);
        bus_reset <= 1'b0;
        repeat (3) @(posedge mclk);
        pulse_ev(6'h10);
        judge(AB | POR, 8'h00, 12'h000);
        `CHK(sync_mode, 1'b0)
        self_start_sync_negotiation_option <= 1'b1;
        $display("t_bus_reset finished");
    endtask
    task automatic t_tags();
        for (logic [7:0] c = 8'h20; c <= 8'h22; c++) begin
            queue_full <= 1'b0;
            mo({48'h0000_0000_0000, c, 8'h05}, 2, -1);
            judge(ENQ, 8'h00, 12'h000);
            queue_full <= 1'b1;
            mo({48'h0000_0000_0000, c, 8'h05}, 2, -1);
            judge(SV, 8'h28, 12'h000);
        end
        queue_full <= 1'b0;
        $display("t_tags finished");
    endtask
    task automatic t_overrun();
        clear();
        for (int i = 0; i < 16; i++) begin
            ini.put(8'h08, 1'b0, 1'b1);
        end
        ini.fin(1'b0);
        repeat (4) @(posedge mclk);
        judge(AB | BF | SS, 8'h00, 12'hB49);
        $display("t_overrun finished");
    endtask
    task automatic t_resel();
        ini.resp_delay = -1;
        clear();
        resel_start <= 1'b1;
        @(posedge mclk);
        resel_start <= 1'b0;
        repeat (TMO - 4) @(posedge mclk);
        `CHK(seen & (RT | AB), 11'h000)
        repeat (TMO + 12) @(posedge mclk);
        judge(RT | AB | SS, 8'h00, 12'h445);
        `CHK(resel_drive, 1'b0)
        ini.resp_delay = 3;
        resel_start <= 1'b1;
        @(posedge mclk);
        resel_start <= 1'b0;
        repeat (8) @(posedge mclk);
        mo(64'h08, 1, -1);
        judge(CR, 8'h00, 12'h000);
        $display("t_resel finished");
    endtask
    initial begin
        repeat (3000) @(posedge mclk);
        fail_count++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        clr <= 1'b0;
        repeat (4) @(posedge mclk);
        t_status();
        t_msgs();
        t_errors();
        t_sync();
        t_bus_reset();
        t_tags();
        t_overrun();
        t_resel();
        test_done();
    end
endmodule
